/* File: rtl/fir_map.vh */
`ifndef FIR_MAP_VH
`define FIR_MAP_VH
// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define FIR_OP_LEGACY_SIG   8'hAB
`define FIR_OP_STD_IDENT    8'h9F
`define FIR_OP_STD_IDENT_Q  8'hAF
`define FIR_OP_ORDERED      8'h90
`define FIR_OP_UNIQUE       8'h4B
`define FIR_OP_PARAM_TABLE  8'h5A
`define FIR_OP_NOP          8'h00
`define FIR_OP_RESET_ARM    8'h66
`define FIR_OP_RESET_DO     8'h99
// ----------------------------------------
// Phase lengths in link clocks (single-line)
// ----------------------------------------
`define FIR_OPCODE_BITS     6'h08
`define FIR_ADDR24_BITS     6'h18
`define FIR_ADDR8_BITS      6'h08
`define FIR_DUMMY_DEFAULT   6'h08
// ----------------------------------------
// Unique number addressing
// ----------------------------------------
`define FIR_UID_ZERO_MSB    8
`define FIR_UID_ZERO_LSB    4
// ----------------------------------------
// Power-down exit delay
// ----------------------------------------
`define FIR_EXIT_DELAY_NS   3000
`define FIR_CLK_PERIOD_NS   10
`define FIR_EXIT_DELAY_CYC  ((`FIR_EXIT_DELAY_NS + `FIR_CLK_PERIOD_NS - 1) / `FIR_CLK_PERIOD_NS)
`endif

/* File: rtl/fir_ident.v */
// Function
// - Legacy signature opcode ABh, three dummy bytes, bits latched rising.
// - Signature byte shifted out MSB first on falling clock edges.
// - Signature repeats while select low; select high ends command.
// - Signature opcode works in both modes and releases deep power down.
// - Standard identification uses 9Fh single-line, AFh quad mode.
// - Outputs maker code then 16-bit type/capacity, MSB first.
// - Maker and type/capacity loop until select rises.
// - Opcode 90h, two dummy bytes, one address byte, latched rising.
// - Address bit zero picks maker-first or signature-first order.
// - Maker and signature alternate while select stays low.
// - Opcode 4Bh, three address bytes, configurable dummy, default eight.
// - Fixed 16-byte unique number output, repeated while clocked.
// - Unique address bits 8..4 zero, bits 3..0 pick start byte.
// - Unique number read framed like fast read in both modes.
// - Opcode 5Ah, three address bytes, dummy default eight, table data.
// - No-operation 00h only clears a pending reset arm.
// - 66h arms reset, 99h executes, any other command cancels arm.
// - No command accepted until power-down exit delay elapses.
// - Signature/release opcode ignored while a write is in progress.
`timescale 1ns/1ps
`default_nettype none
`include "fir_map.vh"

module fir_ident #(
  parameter [7:0]   MAKER_CODE   = 8'h5A, // Arbitrary value
  parameter [7:0]   SIGNATURE    = 8'h3C, // Arbitrary value
  parameter [15:0]  TYPE_CAP     = 16'h1234, // Arbitrary value
  parameter [127:0] UNIQUE_NUM   = 128'h0123456789ABCDEF_FEDCBA9876543210,
  parameter [63:0]  PARAM_TABLE  = 64'h53464450_0601_00FF,
  parameter [5:0]   DUMMY_CLKS   = `FIR_DUMMY_DEFAULT,
  parameter         EXIT_DELAY   = `FIR_EXIT_DELAY_CYC
) (
  // System
  input  wire        clock,
  input  wire        reset,
  // Link pins
  input  wire        selectN,
  input  wire        linkClk,
  input  wire [3:0]  dataIn,
  output reg  [3:0]  dataOut,
  output reg  [3:0]  dataOe,
  // Device state
  input  wire        quadCommandMode,
  input  wire        writeInProgressFlag,
  output reg         deepPowerDown,
  output reg         resetArmed,
  output reg         softResetPulse
);

  // ----------------------------------------
  // Phases
  // ----------------------------------------
  localparam [2:0] PH_OPC   = 3'h0;
  localparam [2:0] PH_ADDR  = 3'h1;
  localparam [2:0] PH_DUMMY = 3'h2;
  localparam [2:0] PH_DATA  = 3'h3;
  localparam [2:0] PH_IGN   = 3'h4;

  localparam [2:0] SRC_SIG  = 3'h0;
  localparam [2:0] SRC_STD  = 3'h1;
  localparam [2:0] SRC_ORD  = 3'h2;
  localparam [2:0] SRC_UID  = 3'h3;
  localparam [2:0] SRC_TBL  = 3'h4;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg       clkOld_q;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      // Link clock resets to its idle low level, select to deselected
      sync1_q  <= 6'h20;
      sync2_q  <= 6'h20;
      clkOld_q <= 1'b0;
    end else begin
      sync1_q  <= {selectN, linkClk, dataIn};
      sync2_q  <= sync1_q;
      clkOld_q <= sync2_q[4];
    end
  end

  // Synced pins and link clock edges, only inside a frame
  wire       selN  = sync2_q[5];
  wire [3:0] din   = sync2_q[3:0];
  wire       rise  = ~selN & sync2_q[4] & ~clkOld_q;
  wire       fall  = ~selN & ~sync2_q[4] & clkOld_q;
  wire       quad  = quadCommandMode;

  // ----------------------------------------
  // Command state
  // ----------------------------------------
  reg [2:0]  phase_q;
  reg [2:0]  src_q;
  reg [7:0]  opc_q;
  reg [23:0] addr_q;
  reg [5:0]  cnt_q;
  reg [5:0]  dummyLen_q;
  reg [6:0]  bitIdx_q;
  reg        opDone_q;
  reg        selOld_q;
  reg [15:0] exitCnt_q;

  // Lane width and shift-in values
  wire [2:0] step   = quad ? 3'h4 : 3'h1;
  wire [5:0] stepW  = {3'h0, step};
  wire [7:0] opcNext = quad ? {opc_q[3:0], din}
                            : {opc_q[6:0], din[0]};
  wire [23:0] addrNext = quad ? {addr_q[19:0], din}
                              : {addr_q[22:0], din[0]};
  wire       busy   = (exitCnt_q != 16'h0000);

  // Loop length and start bit per source
  reg [6:0]  loopLen;
  reg [6:0]  startBit;
  always @* begin
    loopLen  = 7'h08;
    startBit = 7'h00;
    case (src_q)
      SRC_SIG: loopLen = 7'h08;
      SRC_STD: loopLen = 7'h18;
      SRC_ORD: begin
        loopLen  = 7'h10;
        startBit = addr_q[0] ? 7'h08 : 7'h00;
      end
      SRC_UID: begin
        loopLen  = 7'h00;                                  // 128 wraps
        startBit = {addr_q[3:0], 3'h0};
      end
      SRC_TBL: loopLen = 7'h40;
      default: loopLen = 7'h08;
    endcase
  end

  // Current output nibble or bit, MSB first
  reg [7:0] curByte;
  reg [3:0] nib;
  always @* begin
    curByte = SIGNATURE;
    case (src_q)
      SRC_SIG: curByte = SIGNATURE;
      SRC_STD: curByte = (bitIdx_q < 7'h08) ? MAKER_CODE :
                         (bitIdx_q < 7'h10) ? TYPE_CAP[15:8] :
                         TYPE_CAP[7:0];
      SRC_ORD: curByte = (bitIdx_q < 7'h08) ? MAKER_CODE : SIGNATURE;
      SRC_UID: curByte = UNIQUE_NUM[8'd127 - {1'b0, bitIdx_q[6:3], 3'h0}
                                    -: 8];
      SRC_TBL: curByte = PARAM_TABLE[8'd63 - {2'b00, bitIdx_q[5:3], 3'h0}
                                     -: 8];
      default: curByte = SIGNATURE;
    endcase
    nib = bitIdx_q[2] ? curByte[3:0] : curByte[7:4];
  end

  // Output bit index advance with per-source wrap
  wire [6:0] idxInc  = bitIdx_q + {4'h0, step};
  wire [6:0] idxNext = (loopLen != 7'h00 && idxInc >= loopLen)
                       ? 7'h00 : idxInc;

  // ----------------------------------------
  // Command decode and shifting
  // ----------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_q        <= PH_OPC;
      src_q          <= SRC_SIG;
      opc_q          <= 8'h00;
      addr_q         <= 24'h000000;
      cnt_q          <= 6'h00;
      dummyLen_q     <= 6'h00;
      bitIdx_q       <= 7'h00;
      opDone_q       <= 1'b0;
      selOld_q       <= 1'b1;
      exitCnt_q      <= 16'h0000;
      deepPowerDown  <= 1'b0;
      resetArmed     <= 1'b0;
      softResetPulse <= 1'b0;
      dataOut        <= 4'h0;
      dataOe         <= 4'h0;
    end else begin
      selOld_q       <= selN;
      softResetPulse <= 1'b0;
      if (busy)
        exitCnt_q <= exitCnt_q - 16'h0001;
      if (selN) begin
        // Frame end: stop driving and act on framed commands
        dataOe   <= 4'h0;
        phase_q  <= PH_OPC;
        cnt_q    <= 6'h00;
        bitIdx_q <= 7'h00;
        if (!selOld_q && opDone_q) begin
          opDone_q <= 1'b0;
          if (opc_q == `FIR_OP_RESET_DO && resetArmed)
            softResetPulse <= 1'b1;
          resetArmed <= (opc_q == `FIR_OP_RESET_ARM);
          if (opc_q == `FIR_OP_LEGACY_SIG && deepPowerDown
              && !writeInProgressFlag) begin
            deepPowerDown <= 1'b0;
            exitCnt_q     <= EXIT_DELAY[15:0];
          end
        end
      end else if (rise) begin
        case (phase_q)
          PH_OPC: begin
            opc_q <= opcNext;
            if (busy) begin
              phase_q <= PH_IGN;
            end else if (cnt_q + stepW >= `FIR_OPCODE_BITS) begin
              // Opcode complete: decode it unless powered down
              cnt_q    <= 6'h00;
              opDone_q <= 1'b1;
              phase_q  <= PH_IGN;
              dummyLen_q <= DUMMY_CLKS;
              if (deepPowerDown) begin
                phase_q <= PH_IGN;
              end else begin
                case (opcNext)
                  `FIR_OP_LEGACY_SIG: begin
                    if (!writeInProgressFlag) begin
                      src_q      <= SRC_SIG;
                      phase_q    <= PH_DUMMY;
                      dummyLen_q <= quad ? 6'h06 : 6'h18;
                    end
                  end
                  `FIR_OP_STD_IDENT, `FIR_OP_STD_IDENT_Q: begin
                    if (quad == (opcNext == `FIR_OP_STD_IDENT_Q)) begin
                      src_q   <= SRC_STD;
                      phase_q <= PH_DATA;
                    end
                  end
                  `FIR_OP_ORDERED: begin
                    src_q   <= SRC_ORD;
                    phase_q <= PH_ADDR;
                  end
                  `FIR_OP_UNIQUE: begin
                    src_q   <= SRC_UID;
                    phase_q <= PH_ADDR;
                  end
                  `FIR_OP_PARAM_TABLE: begin
                    src_q   <= SRC_TBL;
                    phase_q <= PH_ADDR;
                  end
                  default: phase_q <= PH_IGN;
                endcase
              end
            end else begin
              cnt_q <= cnt_q + stepW;
            end
          end
          PH_ADDR: begin
            addr_q <= addrNext;
            if (cnt_q + stepW >= ((src_q == SRC_ORD) ?
                (`FIR_ADDR8_BITS + 6'h10) : `FIR_ADDR24_BITS)) begin
              cnt_q <= 6'h00;
              // Ordered read: dummies precede its address byte
              phase_q <= (src_q == SRC_ORD) ? PH_DATA : PH_DUMMY;
            end else begin
              cnt_q <= cnt_q + stepW;
            end
          end
          PH_DUMMY: begin
            // One dummy count per link clock in either mode
            if (cnt_q + 6'h01 >= dummyLen_q) begin
              cnt_q   <= 6'h00;
              phase_q <= PH_DATA;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          default: ;
        endcase
      end else if (fall && phase_q == PH_DATA) begin
        // Shift data out on falling edge
        if (src_q == SRC_UID && addr_q[`FIR_UID_ZERO_MSB:`FIR_UID_ZERO_LSB]
            != 5'h00) begin
          dataOe <= 4'h0;
        end else begin
          if (quad) begin
            dataOut <= nib;
            dataOe  <= 4'hF;
          end else begin
            dataOut <= {2'b00, curByte[3'h7 - bitIdx_q[2:0]], 1'b0};
            dataOe  <= 4'h2;
          end
        end
        bitIdx_q <= idxNext;
      end else if (rise == 1'b0 && phase_q == PH_DATA && cnt_q == 6'h00
                   && bitIdx_q == 7'h00 && dataOe == 4'h0) begin
        // Entering data: load the start bit once per frame
        bitIdx_q <= startBit;
        cnt_q    <= 6'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/fir_ident_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module fir_ident_monitor (
  // System
  input wire logic       clock,
  input wire logic       reset,
  // Link pins
  input wire logic       selectN,
  input wire logic       linkClk,
  input wire logic [3:0] dataIn,
  input wire logic [3:0] dataOut,
  input wire logic [3:0] dataOe,
  // Device state
  input wire logic       quadCommandMode,
  input wire logic       writeInProgressFlag,
  input wire logic       deepPowerDown,
  input wire logic       resetArmed,
  input wire logic       softResetPulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Output drive shape and timing
  oe_idle_a: assert property (selectN [*6] |-> dataOe == 4'h0)
    else $error("output driven while deselected");
  oe_width_a: assert property (dataOe != 4'h0 |->
    dataOe == (quadCommandMode ? 4'hF : 4'h2))
    else $error("output enable width wrong for mode");
  oe_start_a: assert property ($rose(dataOe[1]) |-> !selectN && !linkClk)
    else $error("drive began off a falling link edge");
  data_hold_a: assert property (linkClk [*3] |-> $stable(dataOut))
    else $error("output changed while link clock high");
  // Reset arm and power state
  pulse_one_a: assert property (softResetPulse |=> !softResetPulse)
    else $error("reset pulse longer than one cycle");
  pulse_arm_a: assert property (softResetPulse |-> $past(resetArmed))
    else $error("reset executed without arm");
  arm_frame_a: assert property ($changed(resetArmed) |-> selectN)
    else $error("arm changed inside a frame");
  power_state_a: assert property (!deepPowerDown)
    else $error("power down entered with no entry command");
endmodule

bind fir_ident fir_ident_monitor mon (
  .clock, .reset, .selectN, .linkClk, .dataIn, .dataOut, .dataOe,
  .quadCommandMode, .writeInProgressFlag, .deepPowerDown, .resetArmed,
  .softResetPulse
);
`default_nettype wire

/* File: testbench/fir_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host controller model
// ----------------------------------------
module fir_host_model (
  // Link pins
  output var logic       linkClk,
  output var logic       selectN,
  output var logic [3:0] dataIn,
  // Device answer
  input  wire logic [3:0] dataOut,
  input  wire logic [3:0] dataOe
);
  logic [135:0] rd; // Bits taken back, last one at bit 0
  // Idle link: clock still, deselected
  initial begin
    linkClk = 1'b0;
    selectN = 1'b1;
    dataIn  = 4'h0;
  end
  // One framed command; pre holds address and dummy bits
  task automatic xfer(input logic [7:0] op, input logic [31:0] pre,
                      input int preBits, input int rdBits, input logic q);
    logic [39:0] tx;
    int          n;
    int          w;
    int          k;
    w  = q ? 4 : 1;
    tx = {op, pre << (32 - preBits)};
    rd = '0;
    selectN = 1'b0;
    #100;
    for (n = 0; n < 8 + preBits + rdBits; n = n + w) begin
      linkClk = 1'b0;
      if (n < 8 + preBits) begin
        dataIn = q ? tx[39:36] : {dataIn[3:1], tx[39]};
        tx = tx << w;
      end else begin
        dataIn = ~dataIn; // Lines unused by the device keep toggling
      end
      #62.5;
      linkClk = 1'b1;
      if (n >= 8 + preBits) begin
        for (k = w - 1; k >= 0; k--) begin
          rd = {rd[134:0], dataOe[q ? k : 1] ? dataOut[q ? k : 1] : 1'bz};
        end
      end
      #62.5;
    end
    linkClk = 1'b0;
    #62.5;
    selectN = 1'b1;
    dataIn = ~dataIn;
    #500;
  endtask
endmodule
`default_nettype wire

/* File: testbench/fir_ident_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module fir_ident_tb_top;
  localparam logic [7:0]   MK = 8'hC3;    // Arbitrary value
  localparam logic [7:0]   SG = 8'h7E;    // Arbitrary value
  localparam logic [15:0]  TC = 16'hB1D4; // Arbitrary value
  localparam logic [127:0] UN = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [63:0]  PT = 64'hA1B2C3D4E5F60718;
  logic            clock               = 1'b0;
  logic            reset               = 1'b1;
  logic            quadCommandMode     = 1'b0;
  logic            writeInProgressFlag = 1'b0;
  wire logic       selectN;
  wire logic       linkClk;
  wire logic [3:0] dataIn;
  wire logic [3:0] dataOut;
  wire logic [3:0] dataOe;
  wire logic       deepPowerDown;
  wire logic       resetArmed;
  wire logic       softResetPulse;
  int              errors      = 0;
  int              comparisons = 0;
  int              pulses      = 0;
  // Device and host
  fir_ident #(.MAKER_CODE(MK), .SIGNATURE(SG), .TYPE_CAP(TC),
    .UNIQUE_NUM(UN), .PARAM_TABLE(PT), .EXIT_DELAY(4)) uut (
    .clock, .reset, .selectN, .linkClk, .dataIn, .dataOut, .dataOe,
    .quadCommandMode, .writeInProgressFlag, .deepPowerDown, .resetArmed,
    .softResetPulse);
  fir_host_model host (.linkClk, .selectN, .dataIn, .dataOut, .dataOe);
  // Clock and reset pulse count
  always #5 clock = ~clock;
  always @(posedge clock) if (softResetPulse === 1'b1) pulses <= pulses + 1;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [135:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic setIn(input logic q, input logic w);
    @(posedge clock);
    #1;
    quadCommandMode = q;
    writeInProgressFlag = w;
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_legacy;
    host.xfer(8'hAB, 32'h0, 24, 16, 1'b0);
    check("sig", host.rd[15:0], {SG, SG});
    setIn(1'b0, 1'b1);
    host.xfer(8'hAB, 32'h0, 24, 8, 1'b0);
    check("sigBusy", host.rd[7:0], 8'hZZ);
    setIn(1'b1, 1'b0);
    host.xfer(8'hAB, 32'h0, 24, 8, 1'b1);
    check("sigQuad", host.rd[7:0], SG);
    check("power", deepPowerDown, 1'b0);
  endtask
  task automatic t_ident;
    host.xfer(8'hAF, 32'h0, 0, 24, 1'b1);
    check("idQuad", host.rd[23:0], {MK, TC});
    host.xfer(8'h9F, 32'h0, 0, 8, 1'b1);
    check("idWrong", host.rd[7:0], 8'hZZ);
    setIn(1'b0, 1'b0);
    host.xfer(8'h9F, 32'h0, 0, 48, 1'b0);
    check("id", host.rd[47:0], {MK, TC, MK, TC});
  endtask
  task automatic t_ordered;
    for (int a = 0; a < 2; a++) begin
      host.xfer(8'h90, a, 24, 32, 1'b0);
      check("ord", host.rd[31:0],
            a ? {SG, MK, SG, MK} : {MK, SG, MK, SG});
    end
    setIn(1'b1, 1'b0);
    host.xfer(8'h90, 32'h1, 24, 16, 1'b1);
    check("ordQuad", host.rd[15:0], {SG, MK});
    setIn(1'b0, 1'b0);
  endtask
  task automatic t_unique;
    host.xfer(8'h4B, {24'hA5C20F, 8'h00}, 32, 136, 1'b0);
    check("uid", host.rd, {UN[7:0], UN});
    host.xfer(8'h4B, {24'h000010, 8'h00}, 32, 8, 1'b0);
    check("uidBad", host.rd[7:0], 8'hZZ);
  endtask
  task automatic t_param;
    host.xfer(8'h5A, 32'h0, 32, 12, 1'b0);
    check("table", host.rd[11:0], PT[63:52]);
    check("tableOff", dataOe, 4'h0);
  endtask
  task automatic t_reset;
    host.xfer(8'h66, 32'h0, 0, 0, 1'b0);
    check("arm", resetArmed, 1'b1);
    host.xfer(8'h00, 32'h0, 0, 0, 1'b0);
    check("nop", resetArmed, 1'b0);
    host.xfer(8'h66, 32'h0, 0, 0, 1'b0);
    host.xfer(8'h9F, 32'h0, 0, 8, 1'b0);
    check("cancel", resetArmed, 1'b0);
    host.xfer(8'h66, 32'h0, 0, 0, 1'b0);
    host.xfer(8'h99, 32'h0, 0, 0, 1'b0);
    check("pulse", pulses, 1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    t_legacy;
    t_ident;
    t_ordered;
    t_unique;
    t_param;
    t_reset;
    stop_test;
  end
endmodule
`default_nettype wire
